/* File: logic/coord_pkg.sv */
// types shared by the trigger coordinator and its host framer
package coord_pkg;

  typedef enum logic [1:0] {
    MODE_FIRST = 2'h0,
    MODE_IMMED = 2'h1,
    MODE_DEFER = 2'h2
  } read_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_READ  = 5'h04,
    ST_STOP  = 5'h08,
    ST_FLUSH = 5'h10
  } coord_state_t;

  typedef enum logic [3:0] {
    FR_IDLE = 4'h1,
    FR_HDR  = 4'h2,
    FR_DATA = 4'h4,
    FR_DLM  = 4'h8
  } frame_state_t;

  typedef enum logic {
    CMD_START = 1'b0,
    CMD_END   = 1'b1
  } cmd_kind_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  id;
    logic        ok;
    logic [3:0]  len;
    logic [63:0] data;
  } read_result_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  id;
    cmd_kind_t   kind;
    logic [2:0]  len;
    logic [31:0] text;
  } reader_cmd_t;

  typedef struct packed {
    logic [3:0]  len;
    logic [63:0] data;
  } host_msg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] ch;
  } host_char_t;

  typedef struct packed {
    logic       stop2;
    logic       par_odd;
    logic       par_en;
    logic       data8;
    logic [2:0] baud;
  } serial_cfg_t;

endpackage

/* File: logic/coord_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef COORD_REGS_SVH
`define COORD_REGS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define REG_CTRL     8'h00
`define REG_IDS      8'h04
`define REG_SHOT     8'h08
`define REG_SER      8'h0c
`define REG_FRAME    8'h10
`define REG_ERR_LO   8'h14
`define REG_ERR_HI   8'h18
`define REG_CMD_ON   8'h1c
`define REG_CMD_OFF  8'h20
`define REG_CMD_LEN  8'h24
`define REG_STAT     8'h28

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_SHOT_BIT 2
`define CTRL_HOLD_BIT 3
`define CTRL_HDR_BIT  4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CTRL_RST     5'h10
`define IDS_RST      32'h0000_0002
`define SHOT_RST     16'h0064
`define SER_RST      7'h10
`define FRAME_RST    16'h0d02
`define ERR_LO_RST   32'h4f52_5245
`define ERR_HI_RST   12'h552
`define CMD_ON_RST   32'h004e_4f4c
`define CMD_OFF_RST  32'h4646_4f4c
`define CMD_LEN_RST  8'h43

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define TICK_MS       1
`define TICK_CYCLES   ((`TICK_MS * 1000000) / `CLK_PERIOD_NS)

`endif

/* File: logic/host_framer.sv */
// frames one message as header, data characters and delimiter
`timescale 1ns/1ps
`default_nettype none
module host_framer
  import coord_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // message in
  input  wire logic       msg_valid,
  input  wire host_msg_t  msg,
  output logic            msg_ready,
  // framing
  input  wire logic       hdr_en,
  input  wire logic [7:0] hdr_ch,
  input  wire logic [7:0] dlm_ch,
  // host side
  output host_char_t      host_tx,
  input  wire logic       host_ready
);

  frame_state_t st_q, st_d;
  logic [63:0]  data_q, data_d;
  logic [3:0]   left_q, left_d;
  logic [7:0]   ch_q, ch_d;

  // a new message is taken only when the last one is out whole
  assign msg_ready     = (st_q == FR_IDLE);
  assign host_tx.valid = (st_q != FR_IDLE);
  assign host_tx.ch    = ch_q;

  // ------------------------------------------------------------
  // character sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    logic [63:0] src;
    logic [3:0]  cnt;
    logic        go;
    src    = data_q;
    cnt    = left_q;
    go     = 1'b0;
    st_d   = st_q;
    data_d = data_q;
    left_d = left_q;
    ch_d   = ch_q;
    case (st_q)
      FR_IDLE:
      begin
        src = msg.data;
        cnt = msg.len;
        if (msg_valid && hdr_en)
        begin
          st_d   = FR_HDR;
          ch_d   = hdr_ch;
          data_d = msg.data;
          left_d = msg.len;
        end
        else if (msg_valid)
          go = 1'b1;
      end
      FR_HDR, FR_DATA:
        go = host_ready;
      FR_DLM:
        if (host_ready)
          st_d = FR_IDLE;
      default:
        st_d = FR_IDLE;
    endcase
    // data only, no reader id between header and delimiter
    if (go && cnt != 4'h0)
    begin
      st_d   = FR_DATA;
      ch_d   = src[7:0];
      data_d = {8'h00, src[63:8]};
      left_d = cnt - 4'h1;
    end
    else if (go)
    begin
      st_d = FR_DLM;
      ch_d = dlm_ch;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q   <= FR_IDLE;
      data_q <= 64'h0;
      left_q <= 4'h0;
      ch_q   <= 8'h00;
    end
    else
    begin
      st_q   <= st_d;
      data_q <= data_d;
      left_q <= left_d;
      ch_q   <= ch_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_frame_ends_delim: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_q == FR_DLM |-> host_tx.ch == dlm_ch)
    else $error("frame does not end with the delimiter");
  chk_msg_whole: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == FR_DATA && !host_ready) |=> host_tx.valid && $stable(host_tx.ch))
    else $error("host character dropped or changed while stalled");

endmodule // host_framer
`default_nettype wire

/* File: logic/trigger_coordinator.sv */
// multi-reader trigger coordinator: trigger fan-out and read policies
// Behaviour
// - trigger fans out to every connected reader
// - level type reads while trigger held
// - one-shot: rising edge opens timed window
// - first-read mode passes first good result
// - first read switches other readers' light off
// - first-read and immediate modes, nothing read: one error code to host
// - first result immediate, or held till trigger off
// - immediate mode forwards each good result at once
// - immediate mode: failed reader sends nothing
// - deferred mode: after trigger, ascending id order
// - deferred: one message per reader, error if failed
// - bus serial defaults 9600, 7 bits, even, 1 stop
// - error string matches readers, default ERROR
// - start and end commands match readers
// - data and commands are ascii strings
// - start command sent reader by reader
// - host message: header, data, delimiter only
`timescale 1ns/1ps
`default_nettype none
`include "coord_regs.svh"
module trigger_coordinator
  import coord_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // trigger pin
  input  wire logic        trig_pin,
  // reader bus
  input  wire read_result_t rd_res,
  output logic             rd_res_ready,
  output reader_cmd_t      rd_cmd,
  input  wire logic        rd_cmd_ready,
  output serial_cfg_t      bus_cfg,
  // host link
  output host_char_t       host_tx,
  input  wire logic        host_ready
);

  localparam int TW = $clog2(TICK_CYCLES);

  // lowest present id above 'from', or found bit clear
  function automatic logic [5:0] next_id(input logic [31:0] mask,
                                         input logic [4:0]  from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 1; i--)
      if (i > int'(from) && mask[i])
        r = {1'b1, 5'(i)};
    return r;
  endfunction

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [4:0]   ctrl_q;
  logic [31:0]  ids_q;
  logic [15:0]  shot_ms_q;
  serial_cfg_t  ser_q;
  logic [15:0]  frame_q;
  logic [31:0]  err_lo_q;
  logic [11:0]  err_hi_q;
  logic [31:0]  cmd_on_q;
  logic [31:0]  cmd_off_q;
  logic [7:0]   cmd_len_q;
  logic [31:0]  rd_mux;
  logic [31:0]  stat;

  read_mode_t   mode;
  logic         oneshot;
  logic         hold;
  logic [31:0]  mask_all;

  assign mode     = read_mode_t'(ctrl_q[`CTRL_MODE_LSB +: 2]);
  assign oneshot  = ctrl_q[`CTRL_SHOT_BIT];
  assign hold     = ctrl_q[`CTRL_HOLD_BIT];
  assign mask_all = {ids_q[31:1], 1'b0}; // id 0 never addresses a reader
  assign bus_cfg  = ser_q;

  // software writes, all fields at once per word
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q    <= `CTRL_RST;
      ids_q     <= `IDS_RST;
      shot_ms_q <= `SHOT_RST;
      ser_q     <= `SER_RST;
      frame_q   <= `FRAME_RST;
      err_lo_q  <= `ERR_LO_RST;
      err_hi_q  <= `ERR_HI_RST;
      cmd_on_q  <= `CMD_ON_RST;
      cmd_off_q <= `CMD_OFF_RST;
      cmd_len_q <= `CMD_LEN_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `REG_CTRL:    ctrl_q    <= reg_wdata[4:0];
        `REG_IDS:     ids_q     <= reg_wdata;
        `REG_SHOT:    shot_ms_q <= reg_wdata[15:0];
        `REG_SER:     ser_q     <= serial_cfg_t'(reg_wdata[6:0]);
        `REG_FRAME:   frame_q   <= reg_wdata[15:0];
        `REG_ERR_LO:  err_lo_q  <= reg_wdata;
        `REG_ERR_HI:  err_hi_q  <= reg_wdata[11:0];
        `REG_CMD_ON:  cmd_on_q  <= reg_wdata;
        `REG_CMD_OFF: cmd_off_q <= reg_wdata;
        `REG_CMD_LEN: cmd_len_q <= reg_wdata[7:0];
        default:      ;
      endcase
    end
  end

  // read selection; unmapped offsets read as zero
  always_comb
  begin
    case (reg_addr)
      `REG_CTRL:    rd_mux = {27'h0, ctrl_q};
      `REG_IDS:     rd_mux = mask_all;
      `REG_SHOT:    rd_mux = {16'h0, shot_ms_q};
      `REG_SER:     rd_mux = {25'h0, ser_q};
      `REG_FRAME:   rd_mux = {16'h0, frame_q};
      `REG_ERR_LO:  rd_mux = err_lo_q;
      `REG_ERR_HI:  rd_mux = {20'h0, err_hi_q};
      `REG_CMD_ON:  rd_mux = cmd_on_q;
      `REG_CMD_OFF: rd_mux = cmd_off_q;
      `REG_CMD_LEN: rd_mux = {24'h0, cmd_len_q};
      `REG_STAT:    rd_mux = stat;
      default:      rd_mux = 32'h0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  // ------------------------------------------------------------
  // trigger window
  // ------------------------------------------------------------
  logic          trig_m_q, trig_s_q, trig_d_q;
  logic [TW-1:0] tick_q;
  logic [15:0]   shot_q;
  logic          win_q, win_now, win_rise, win_fall, trig_rise, tick;

  assign trig_rise = trig_s_q && !trig_d_q;
  assign tick      = (tick_q == TW'(TICK_CYCLES - 1));
  // level follows the pin, one-shot follows the ms countdown
  assign win_now   = oneshot ? (shot_q != 16'h0) : trig_s_q;
  assign win_rise  = win_now && !win_q;
  assign win_fall  = !win_now && win_q;

  // pin synchroniser, then edge history and the ms timer
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trig_m_q <= 1'b0;
      trig_s_q <= 1'b0;
      trig_d_q <= 1'b0;
      win_q    <= 1'b0;
      tick_q   <= '0;
      shot_q   <= 16'h0;
    end
    else
    begin
      trig_m_q <= trig_pin;
      trig_s_q <= trig_m_q;
      trig_d_q <= trig_s_q;
      win_q    <= win_now;
      // restarting the divider on an edge keeps the window exact
      tick_q   <= (tick || (oneshot && trig_rise)) ? '0 : tick_q + TW'(1);
      if (oneshot && trig_rise)
        shot_q <= shot_ms_q;
      else if (!oneshot)
        shot_q <= 16'h0;
      else if (tick && shot_q != 16'h0)
        shot_q <= shot_q - 16'h1;
    end
  end

  // ------------------------------------------------------------
  // result capture
  // ------------------------------------------------------------
  coord_state_t st_q, st_d;
  logic         have_q, have_d, kill_act_q, kill_act_d;
  logic [4:0]   idx_q, idx_d, win_id_q;
  logic         kill_pend_q, end_pend_q, got_q;
  logic [31:0]  ok_q;
  logic [63:0]  store_q [32];
  logic [3:0]   slen_q [32];
  logic [31:0]  kill_mask, scan_mask;
  logic         collecting, res_hit, fwd_need, accept_ok, win_evt, store_wr;
  logic         msg_valid, msg_ready, msg_fire, cmd_fire, need_one;
  host_msg_t    msg, err_msg, flush_msg;

  assign kill_mask  = mask_all & ~(32'h1 << win_id_q);
  assign scan_mask  = kill_act_q ? kill_mask : mask_all;
  assign collecting = (st_q == ST_START || st_q == ST_READ)
                      && !(mode == MODE_FIRST && got_q);
  assign res_hit    = rd_res.valid && mask_all[rd_res.id];
  // failed reads are swallowed here in immediate mode
  assign fwd_need   = collecting && res_hit && rd_res.ok
                      && (mode == MODE_IMMED
                          || (mode == MODE_FIRST && !hold));
  // a reader waits rather than cut into a message on its way out
  assign rd_res_ready = !fwd_need || msg_ready;
  assign accept_ok  = rd_res.valid && rd_res_ready && collecting && res_hit && rd_res.ok;
  assign win_evt    = accept_ok && mode == MODE_FIRST;
  assign store_wr   = accept_ok && (mode == MODE_DEFER || (mode == MODE_FIRST && hold));

  // results are kept per reader id until the flush
  always_ff @(posedge clk_sys)
  begin
    if (store_wr)
    begin
      store_q[rd_res.id] <= rd_res.data;
      slen_q[rd_res.id]  <= rd_res.len;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ok_q        <= 32'h0;
      got_q       <= 1'b0;
      win_id_q    <= 5'h0;
      kill_pend_q <= 1'b0;
      end_pend_q  <= 1'b0;
    end
    else
    begin
      if (st_q == ST_IDLE && win_rise)
        ok_q <= 32'h0;
      else if (store_wr)
        ok_q[rd_res.id] <= 1'b1;
      if (st_q == ST_IDLE && win_rise)
        got_q <= 1'b0;
      else if (accept_ok)
        got_q <= 1'b1;
      if (win_evt)
        win_id_q <= rd_res.id;
      // the event wins over its own clear
      // a winner seen as the end scan starts must not leak into the next trigger
      kill_pend_q <= win_evt || (kill_pend_q && !(st_q == ST_READ)
                                 && !(st_q == ST_IDLE && win_rise));
      end_pend_q  <= win_fall || (end_pend_q && !(st_q == ST_READ && !kill_pend_q)
                                 && !(st_q == ST_IDLE && win_rise));
    end
  end

  // ------------------------------------------------------------
  // sequencing of commands and flush
  // ------------------------------------------------------------
  assign cmd_fire    = rd_cmd.valid && rd_cmd_ready;
  assign msg_fire    = msg_valid && msg_ready;
  assign need_one    = (mode == MODE_FIRST) ? (!got_q || hold) : !got_q;
  assign err_msg     = '{len: err_hi_q[11:8], data: {24'h0, err_hi_q[7:0], err_lo_q}};
  // a reader with nothing stored answers with the error string
  assign flush_msg   = ok_q[idx_q] ? host_msg_t'{len: slen_q[idx_q], data: store_q[idx_q]}
                                   : err_msg;
  assign msg_valid   = (st_q == ST_FLUSH) ? have_q : fwd_need;
  assign msg         = (st_q == ST_FLUSH) ? flush_msg
                                          : host_msg_t'{len: rd_res.len, data: rd_res.data};
  // commands go to one reader at a time, lowest id first
  assign rd_cmd.valid = (st_q == ST_START || st_q == ST_STOP) && have_q;
  assign rd_cmd.id    = idx_q;
  assign rd_cmd.kind  = (st_q == ST_STOP) ? CMD_END : CMD_START;
  assign rd_cmd.len   = (st_q == ST_STOP) ? cmd_len_q[6:4] : cmd_len_q[2:0];
  assign rd_cmd.text  = (st_q == ST_STOP) ? cmd_off_q : cmd_on_q;
  assign stat = {14'h0, got_q, kill_act_q, 2'h0, win_id_q, 3'h0, have_q, st_q};

  always_comb
  begin
    st_d       = st_q;
    have_d     = have_q;
    idx_d      = idx_q;
    kill_act_d = kill_act_q;
    case (st_q)
      ST_IDLE:
        if (win_rise)
        begin
          st_d              = ST_START;
          {have_d, idx_d}   = next_id(mask_all, 5'h0);
        end
      ST_START:
        if (!have_q)
          st_d = ST_READ;
        else if (cmd_fire)
          {have_d, idx_d} = next_id(mask_all, idx_q);
      ST_READ:
        if (kill_pend_q)
        begin
          st_d            = ST_STOP;
          kill_act_d      = 1'b1;
          {have_d, idx_d} = next_id(kill_mask, 5'h0);
        end
        else if (end_pend_q)
        begin
          st_d            = ST_STOP;
          {have_d, idx_d} = next_id(mask_all, 5'h0);
        end
      ST_STOP:
        if (!have_q && kill_act_q)
        begin
          st_d       = ST_READ;
          kill_act_d = 1'b0;
        end
        else if (!have_q)
        begin
          st_d = ST_FLUSH;
          if (mode == MODE_DEFER)
            {have_d, idx_d} = next_id(mask_all, 5'h0);
          else
          begin
            have_d = need_one;
            idx_d  = got_q ? win_id_q : 5'h0;
          end
        end
        else if (cmd_fire)
          {have_d, idx_d} = next_id(scan_mask, idx_q);
      ST_FLUSH:
        if (!have_q)
          st_d = ST_IDLE;
        else if (msg_fire && mode == MODE_DEFER)
          {have_d, idx_d} = next_id(mask_all, idx_q);
        else if (msg_fire)
          have_d = 1'b0;
      default:
        st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q       <= ST_IDLE;
      have_q     <= 1'b0;
      idx_q      <= 5'h0;
      kill_act_q <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      have_q     <= have_d;
      idx_q      <= idx_d;
      kill_act_q <= kill_act_d;
    end
  end

  // ------------------------------------------------------------
  // host framing
  // ------------------------------------------------------------
  host_framer u_framer (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .msg_valid  (msg_valid),
    .msg        (msg),
    .msg_ready  (msg_ready),
    .hdr_en     (ctrl_q[`CTRL_HDR_BIT]),
    .hdr_ch     (frame_q[7:0]),
    .dlm_ch     (frame_q[15:8]),
    .host_tx    (host_tx),
    .host_ready (host_ready)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_win_taken;
    // with an end scan already due every reader is switched off anyway
    win_evt && st_q == ST_READ && !kill_pend_q && !end_pend_q;
  endsequence
  sequence s_kill_scan;
    kill_pend_q ##1 (st_q == ST_STOP && kill_act_q);
  endsequence

  chk_start_fanout: assert property (
    st_q == ST_IDLE && win_rise |=> st_q == ST_START && rd_cmd.kind == CMD_START)
    else $error("trigger did not start the reader fan-out");
  chk_level_stop: assert property (
    !oneshot && st_q == ST_READ && end_pend_q && !kill_pend_q |=> st_q == ST_STOP)
    else $error("level trigger release did not stop the readers");
  chk_shot_open: assert property (
    oneshot && trig_rise && shot_ms_q != 16'h0 |=> shot_q == $past(shot_ms_q))
    else $error("one-shot window not loaded on the rising edge");
  chk_first_only: assert property (
    mode == MODE_FIRST && got_q && st_q != ST_FLUSH |-> !accept_ok)
    else $error("second result taken in first-read mode");
  chk_light_off: assert property (s_win_taken |=> s_kill_scan)
    else $error("other readers not switched off after first read");
  chk_kill_skips: assert property (
    st_q == ST_STOP && kill_act_q && have_q |-> idx_q != win_id_q)
    else $error("winning reader sent the end command");
  chk_one_error: assert property (
    st_q == ST_STOP && !have_q && !kill_act_q && mode != MODE_DEFER && !got_q
    |=> st_q == ST_FLUSH && have_q && msg == err_msg)
    else $error("no read error issued for an empty window");
  chk_hold_first: assert property (
    mode == MODE_FIRST && hold && st_q != ST_FLUSH |-> !msg_valid)
    else $error("held first result sent before trigger end");
  chk_fwd_now: assert property (
    mode == MODE_IMMED && collecting && res_hit && rd_res.ok |-> msg_valid)
    else $error("good result not forwarded at once");
  chk_no_fail_msg: assert property (
    mode == MODE_IMMED && st_q != ST_FLUSH && msg_valid |-> rd_res.ok)
    else $error("failed read produced a host message");
  chk_defer_order: assert property (
    st_q == ST_FLUSH && mode == MODE_DEFER && msg_fire |=> !have_q || idx_q > $past(idx_q))
    else $error("deferred results out of id order");
  chk_defer_err: assert property (
    st_q == ST_FLUSH && have_q && !ok_q[idx_q] |-> msg == err_msg)
    else $error("failed reader did not yield the error string");

endmodule // trigger_coordinator
`default_nettype wire

/* File: verification/reader_bus_model.sv */
// reader bus partner: every started reader answers one result unless ended first, good only if it decodes
`timescale 1ns/1ps
`default_nettype none
module reader_bus_model
  import coord_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // reader bus
  input  wire reader_cmd_t  rd_cmd,
  output logic             rd_cmd_ready,
  output read_result_t     rd_res,
  input  wire logic        rd_res_ready,
  // readers that decode
  input  wire logic [31:0] good_ids
);
  logic [31:0] pend_q;
  logic [4:0]  nxt;
  // lowest started reader answers first; readers outside good_ids report a failed read
  always_comb
  begin
    nxt = 5'h0;
    for (int i = 31; i > 0; i--)
      if (pend_q[i]) nxt = 5'(i);
  end
  // read from start command to end command; a released result is scrambled
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_q       <= 32'h0;
      rd_res       <= '0;
      rd_cmd_ready <= 1'b0;
    end
    else
    begin
      rd_cmd_ready <= 1'($urandom);
      if (rd_cmd.valid && rd_cmd_ready)
        pend_q[rd_cmd.id] <= (rd_cmd.kind == CMD_START);
      if (rd_res.valid && rd_res_ready)
      begin
        rd_res.valid      <= 1'b0;
        rd_res.data       <= ~rd_res.data;
        pend_q[rd_res.id] <= 1'b0;
      end
      else if (!rd_res.valid && nxt != 5'h0 && 1'($urandom))
        rd_res <= '{1'b1, nxt, good_ids[nxt], 4'h1, {56'h0, 3'h2, nxt}};
    end
  end
endmodule // reader_bus_model
`default_nettype wire

/* File: verification/trigger_coordinator_tb.sv */
// self-checking bench for the trigger coordinator
`timescale 1ns/1ps
`default_nettype none
`include "coord_regs.svh"
module trigger_coordinator_tb;
  import coord_pkg::*;
  typedef logic [7:0] bq_t[$];
  logic         clk_sys = 1'b0;
  logic         arst_n = 1'b0;
  logic [7:0]   reg_addr = 8'h0;
  logic [31:0]  reg_wdata = 32'h0;
  logic [31:0]  reg_rdata;
  logic [31:0]  rv;
  logic [31:0]  good_ids = 32'h0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic         trig_pin = 1'b0;
  logic         host_ready = 1'b0;
  logic         rd_res_ready;
  logic         rd_cmd_ready;
  read_result_t rd_res;
  reader_cmd_t  rd_cmd;
  host_char_t   host_tx;
  serial_cfg_t  bus_cfg;
  int           n_end = 0;
  bq_t          seen;
  int           n_fail = 0;
  int           n_tests = 0;
  int           n_start = 0;
  int           cyc = 0;
  always #10 clk_sys = ~clk_sys;
  trigger_coordinator #(.TICK_CYCLES(10)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_pin(trig_pin), .rd_res(rd_res), .rd_res_ready(rd_res_ready),
    .rd_cmd(rd_cmd), .rd_cmd_ready(rd_cmd_ready), .bus_cfg(bus_cfg), .host_tx(host_tx),
    .host_ready(host_ready));
  reader_bus_model model (.clk_sys(clk_sys), .arst_n(arst_n), .rd_cmd(rd_cmd),
    .rd_cmd_ready(rd_cmd_ready), .rd_res(rd_res), .rd_res_ready(rd_res_ready),
    .good_ids(good_ids));
  // host stalls at random; collect host characters, count commands with their texts, cut hangs
  always @(posedge clk_sys)
  begin
    host_ready <= 1'($urandom);
    if (host_tx.valid && host_ready) seen.push_back(host_tx.ch);
    if (rd_cmd.valid && rd_cmd_ready && rd_cmd.kind == CMD_START && rd_cmd.len == 3'h3
        && rd_cmd.text == `CMD_ON_RST) n_start++;
    if (rd_cmd.valid && rd_cmd_ready && rd_cmd.kind == CMD_END && rd_cmd.len == 3'h4
        && rd_cmd.text == `CMD_OFF_RST) n_end++;
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  function automatic bq_t ok_msg(logic [7:0] id);
    return {8'h02, 8'h40 | id, 8'h0d};
  endfunction
  function automatic bq_t err_msg();
    return {8'h02, 8'h45, 8'h52, 8'h52, 8'h4f, 8'h52, 8'h0d};
  endfunction
  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // one trigger: readers 1 and 3 present, short pulse for one-shot
  task automatic run(logic [31:0] ctrl, logic [31:0] good, bq_t exp, bit shot);
    seen.delete();
    n_start = 0;
    n_end = 0;
    good_ids <= good;
    reg_write(`REG_CTRL, ctrl);
    trig_pin <= 1'b1;
    repeat (shot ? 3 : 60) @(posedge clk_sys);
    trig_pin <= 1'b0;
    repeat (300) @(posedge clk_sys);
    reg_read(`REG_STAT, rv);
    check("state", rv[4:0], 32'h1);
    check("starts", n_start, 32'h2);
    check("ends", n_end, (ctrl[1:0] == 2'h0 && good != 32'h0) ? 32'h3 : 32'h2);
    check("count", seen.size(), exp.size());
    foreach (exp[i]) check("char", seen[i], exp[i]);
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // reset values, then every reading mode and trigger type
  initial
  begin
    rv = $urandom(32'h829d);
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    reg_read(`REG_SER, rv);
    check("ser", rv, 32'h10);
    check("bus cfg", {25'h0, bus_cfg}, 32'h10);
    reg_read(`REG_ERR_LO, rv);
    check("err", rv, 32'h4f52_5245);
    reg_read(8'h3c, rv);
    check("unmapped", rv, 32'h0);
    reg_write(`REG_SER, 32'h15);
    reg_read(`REG_SER, rv);
    check("ser fast", rv, 32'h15);
    check("bus cfg fast", {25'h0, bus_cfg}, 32'h15);
    reg_write(`REG_IDS, 32'ha);
    reg_write(`REG_SHOT, 32'h3);
    run(32'h11, 32'h2, ok_msg(8'h1), 1'b0);
    run(32'h01, 32'ha, {8'h41, 8'h0d, 8'h43, 8'h0d}, 1'b0);
    run(32'h12, 32'h8, {err_msg(), ok_msg(8'h3)}, 1'b0);
    run(32'h10, 32'h0, err_msg(), 1'b0);
    run(32'h10, 32'ha, ok_msg(8'h1), 1'b0);
    run(32'h18, 32'h8, ok_msg(8'h3), 1'b0);
    run(32'h16, 32'h0, {err_msg(), err_msg()}, 1'b1);
    give_verdict();
  end
endmodule // trigger_coordinator_tb
`default_nettype wire
